// File: shared/swdr_pkg.sv
// swdr_pkg: constants and types for the strobe watchdog reset block
// assumes a single 200 MHz clock domain
`default_nettype none
package swdr_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned TICK_CYCLES      = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned TIMEOUT_GND_MS   = 150;
  localparam int unsigned TIMEOUT_OPEN_MS  = 600;
  localparam int unsigned TIMEOUT_VCC_MS   = 1200;
  localparam int unsigned HOLD_MIN_MS      = 250;
  localparam int unsigned MS_W             = 12;

  // ----------------------------------------
  // select encoding of the three-level pin
  // ----------------------------------------
  typedef enum logic [1:0] {
    SWDR_SEL_GND  = 2'h0,
    SWDR_SEL_OPEN = 2'h1,
    SWDR_SEL_VCC  = 2'h2
  } swdr_sel_t;

  typedef enum logic [1:0] {
    SWDR_ST_RUN  = 2'h1,
    SWDR_ST_HOLD = 2'h2
  } swdr_state_t;

  typedef struct packed {
    logic rst_hi;
    logic rst_lo_oe;
  } swdr_rst_t;
endpackage
`default_nettype wire

// File: core/swdr_top.sv
// swdr_top: strobe watchdog with complementary reset outputs
// assumes the timeout select pin is resolved outside into two level inputs
// and the open-drain output is pulled up outside the block
`default_nettype none

// How it works
// - no falling edge for timeout: assert resets
// - select gnd 150, open 600, vcc 1200 ms
// - count restarts when resets go inactive
// - falling strobe edge restarts full period
// - hold resets active at least 250 ms
// - only falling edges count as service
// - actual timeout inside min/max window
// - active-high push-pull plus active-low open-drain
module swdr_top
  import swdr_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES,
  parameter int unsigned TO_GND_MS  = TIMEOUT_GND_MS,
  parameter int unsigned TO_OPEN_MS = TIMEOUT_OPEN_MS,
  parameter int unsigned TO_VCC_MS  = TIMEOUT_VCC_MS,
  parameter int unsigned HOLD_MS    = HOLD_MIN_MS
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic WATCHDOG_STROBE_N_I,
  input  wire logic TIMEOUT_SELECT_HI_I,
  input  wire logic TIMEOUT_SELECT_LO_I,
  output logic      RST_O,
  output logic      RST_N_O,
  output logic      RST_N_OE_O
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] strb_sync_r;
  logic [1:0] sel_hi_sync_r;
  logic [1:0] sel_lo_sync_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strb_sync_r   <= 3'h7;
      sel_hi_sync_r <= 2'h0;
      sel_lo_sync_r <= 2'h0;
    end else begin
      strb_sync_r   <= {strb_sync_r[1:0], WATCHDOG_STROBE_N_I};
      sel_hi_sync_r <= {sel_hi_sync_r[0], TIMEOUT_SELECT_HI_I};
      sel_lo_sync_r <= {sel_lo_sync_r[0], TIMEOUT_SELECT_LO_I};
    end
  end

  // edge is taken from stages 2 and 3 so stage 1 feeds nothing else
  wire strobe_fall = strb_sync_r[2] & ~strb_sync_r[1];

  // hi and lo both sensed high: tied to supply; both low: grounded; else open
  wire       sel_hi = sel_hi_sync_r[1];
  wire       sel_lo = sel_lo_sync_r[1];
  swdr_sel_t sel;
  assign sel = (sel_hi & sel_lo) ? SWDR_SEL_VCC :
               (~sel_hi & ~sel_lo) ? SWDR_SEL_GND : SWDR_SEL_OPEN;

  function automatic logic [MS_W-1:0] period_ms(input swdr_sel_t s);
    unique case (s)
      SWDR_SEL_GND:  period_ms = MS_W'(TO_GND_MS);
      SWDR_SEL_VCC:  period_ms = MS_W'(TO_VCC_MS);
      default:       period_ms = MS_W'(TO_OPEN_MS);
    endcase
  endfunction

  wire [MS_W-1:0] timeout_ms = period_ms(sel);

  // ----------------------------------------
  // millisecond tick divider
  // ----------------------------------------
  logic [31:0] div_r;
  logic        tick_r;
  wire         div_end = (div_r == TICK_CYC - 1);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_end ? 32'h0 : div_r + 32'h1;
      tick_r <= div_end;
    end
  end

  // ----------------------------------------
  // watchdog state machine
  // ----------------------------------------
  swdr_state_t state_r;
  swdr_state_t state_nxt;
  logic [MS_W-1:0] ms_r;
  logic [MS_W-1:0] ms_nxt;

  // a period may end up to one tick early; well inside the min/max window
  wire expired  = tick_r && (ms_r + MS_W'(1) >= timeout_ms);
  wire hold_end = tick_r && (ms_r >= MS_W'(HOLD_MS));

  always_comb begin
    state_nxt = state_r;
    ms_nxt    = ms_r;
    unique case (state_r)
      SWDR_ST_RUN: begin
        if (strobe_fall) begin
          ms_nxt = '0;
        end else if (expired) begin
          state_nxt = SWDR_ST_HOLD;
          ms_nxt    = '0;
        end else if (tick_r) begin
          ms_nxt = ms_r + MS_W'(1);
        end
      end
      SWDR_ST_HOLD: begin
        if (hold_end) begin
          state_nxt = SWDR_ST_RUN;
          ms_nxt    = '0;
        end else if (tick_r) begin
          ms_nxt = ms_r + MS_W'(1);
        end
      end
      default: begin
        state_nxt = SWDR_ST_HOLD;
        ms_nxt    = '0;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= SWDR_ST_RUN;
      ms_r    <= '0;
    end else begin
      state_r <= state_nxt;
      ms_r    <= ms_nxt;
    end
  end

  // ----------------------------------------
  // reset outputs
  // ----------------------------------------
  swdr_rst_t out_r;
  wire       hold_nxt = (state_nxt == SWDR_ST_HOLD);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      out_r <= '0;
    end else begin
      out_r <= '{rst_hi: hold_nxt, rst_lo_oe: hold_nxt};
    end
  end

  assign RST_O      = out_r.rst_hi;
  assign RST_N_OE_O = out_r.rst_lo_oe;
  // open-drain: only ever drives low
  assign RST_N_O    = 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [MS_W-1:0] ms_prev_r;
  logic [31:0]     run_cyc_r;
  logic [31:0]     hold_cyc_r;

  // raw cycle counts cross-check the tick divider: a stalled or miscounting
  // divider would still pass the millisecond checks but not these
  wire        run_clr      = (state_r != SWDR_ST_RUN) || strobe_fall;
  wire [31:0] win_lo       = 32'(timeout_ms - MS_W'(1)) * TICK_CYC;
  wire [31:0] win_hi       = 32'(timeout_ms) * TICK_CYC;
  wire [31:0] hold_min_cyc = 32'(HOLD_MS * TICK_CYC);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ms_prev_r  <= '0;
      run_cyc_r  <= 32'h0;
      hold_cyc_r <= 32'h0;
    end else begin
      ms_prev_r  <= ms_r;
      run_cyc_r  <= run_clr ? 32'h0 : run_cyc_r + 32'h1;
      hold_cyc_r <= RST_O ? hold_cyc_r + 32'h1 : 32'h0;
    end
  end

  sequence s_fall_in_run;
    state_r == SWDR_ST_RUN && strobe_fall && !expired;
  endsequence

  sequence s_expire_in_run;
    state_r == SWDR_ST_RUN && expired && !strobe_fall;
  endsequence

  a_outputs_paired: assert property (@(posedge CLK_I) disable iff (RST_I)
    RST_O == RST_N_OE_O) else $error("reset outputs disagree");
  a_expiry_asserts: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_expire_in_run |=> RST_O)
    else $error("expiry did not assert reset");
  a_expiry_window: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_expire_in_run |-> (run_cyc_r >= win_lo && run_cyc_r <= win_hi))
    else $error("expiry outside the timeout window");

  a_fall_restarts: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_fall_in_run |=> (ms_r == '0 && !RST_O)) else $error("strobe did not restart");
  a_rise_ignored: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state_r == SWDR_ST_RUN && $rose(strb_sync_r[2]) && !tick_r && ms_r != '0)
    |=> ms_r == $past(ms_r)) else $error("rising edge restarted timer");

  a_hold_min: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(RST_O) |-> ms_prev_r >= MS_W'(HOLD_MS)) else $error("reset hold too short");
  a_hold_cycles: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(RST_O) |-> hold_cyc_r >= hold_min_cyc) else $error("reset hold cycles short");
  a_hold_ignores: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state_r == SWDR_ST_HOLD && strobe_fall && !hold_end)
    |=> (state_r == SWDR_ST_HOLD && RST_O)) else $error("strobe cut the reset hold");

  a_run_restart: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(RST_O) |-> ms_r == '0) else $error("count not restarted on release");
  a_run_bound: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == SWDR_ST_RUN |-> ms_r < timeout_ms) else $error("timeout overrun");
  a_sync_reset: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(strb_sync_r[1]) && state_r == SWDR_ST_RUN && !expired |=> ms_r == '0)
    else $error("synchronised edge missed");
endmodule
`default_nettype wire

// File: testbench/swdr_cpu_model.sv
// swdr_cpu_model: processor side that toggles the watchdog strobe
// assumes the bench enables it and gives the half period in clock cycles
`default_nettype none
module swdr_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic [15:0] half_i,
  output var  logic        strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  initial strobe_n_o = 1'b1;
  initial cnt = 16'h0;
  // toggles every half_i cycles from a single code path, well inside the period
  always @(negedge clk_i) begin
    if (en_i) begin
      cnt <= (cnt >= half_i - 16'h1) ? 16'h0 : cnt + 16'h1;
      if (cnt >= half_i - 16'h1)
        strobe_n_o <= ~strobe_n_o;
    end
  end
endmodule
`default_nettype wire

// File: testbench/swdr_top_tb.sv
// swdr_top_tb: self-checking bench for the strobe watchdog
// assumes shortened ticks of 10 cycles; a strobe or reset change lands at negedge
`default_nettype none
module swdr_top_tb
  import swdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  localparam int TG = 15;
  localparam int HM = 25;
  logic        clk_i, rst_i, sel_hi, sel_lo, en, bench_st, rst_o, rst_n, rst_oe, cpu_st;
  logic [15:0] half;
  int          mismatches, n_checks, cyc;
  wire logic   strobe = en ? cpu_st : bench_st;
  swdr_top #(.TICK_CYC(TK), .TO_GND_MS(TG), .TO_OPEN_MS(60), .TO_VCC_MS(120),
    .HOLD_MS(HM)) u_dut (.CLK_I(clk_i), .RST_I(rst_i), .WATCHDOG_STROBE_N_I(strobe),
    .TIMEOUT_SELECT_HI_I(sel_hi), .TIMEOUT_SELECT_LO_I(sel_lo), .RST_O(rst_o),
    .RST_N_O(rst_n), .RST_N_OE_O(rst_oe));
  swdr_cpu_model u_cpu (.clk_i(clk_i), .en_i(en), .half_i(half), .strobe_n_o(cpu_st));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string what, logic got, logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    chk("idle_hi", rst_o, 1'b0);
    chk("idle_od", rst_oe, 1'b0);
  endtask
  // bounded so a stuck output cannot hang the run
  task automatic wait_lvl(logic lvl, output int n);
    n = 0;
    while (rst_o !== lvl && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    if (rst_o !== lvl) begin
      mismatches++;
      complete_run();
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic expire(logic hi, logic lo, int t);
    int n;
    en = 1'b0;
    bench_st = 1'b1;
    sel_hi = hi;
    sel_lo = lo;
    do_reset();
    wait_lvl(1'b1, n);
    chk("to_min", n >= (t - 1) * TK, 1'b1);
    chk("to_max", n <= (t + 1) * TK, 1'b1);
    chk("od_enable", rst_oe, 1'b1);
    chk("od_data", rst_n, 1'b0);
    wait_lvl(1'b0, n);
    chk("hold_min", n >= HM * TK, 1'b1);
    chk("od_release", rst_oe, 1'b0);
    wait_lvl(1'b1, n);
    chk("restart", n >= (t - 1) * TK, 1'b1);
    chk("restart_max", n <= (t + 1) * TK, 1'b1);
  endtask
  task automatic serviced();
    int n;
    int hits;
    hits = 0;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    half = 16'h32;
    bench_st = 1'b1;
    en = 1'b1;
    do_reset();
    repeat (TG * TK * 4) begin
      @(negedge clk_i);
      hits += int'(rst_o !== 1'b0);
    end
    chk("serviced", hits == 0, 1'b1);
    en = 1'b0;
    repeat (5) @(negedge clk_i);
    bench_st = 1'b0;
    repeat (100) @(negedge clk_i);
    bench_st = 1'b1;
    wait_lvl(1'b1, n);
    // the rising edge must not have restarted the count
    chk("rise_ignored", n + 100 <= (TG + 1) * TK, 1'b1);
    chk("fall_counted", n + 100 >= (TG - 1) * TK, 1'b1);
    // strobing during the hold must not shorten it
    en = 1'b1;
    wait_lvl(1'b0, n);
    chk("hold_refuses", n >= HM * TK, 1'b1);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {rst_i, sel_hi, sel_lo, en, bench_st, half} = {5'h11, 16'h32};
    expire(1'b0, 1'b0, TG);
    expire(1'b1, 1'b0, 60);
    expire(1'b1, 1'b1, 120);
    serviced();
    complete_run();
  end
endmodule
`default_nettype wire
